// ===== core/bwu_bus_wait_unit.sv
// bus wait unit: block decode, select lines, cycle type and wait timing
`timescale 1ns/1ps
module bwu_bus_wait_unit
  import bwu_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // request from the core
  input wire bwu_req_type i_req,
  // configuration bits
  input wire bwu_cfg_type i_cfg,
  // ready pin from the bus, asynchronous
  input wire logic i_ready_n,
  // outputs
  output logic [3:0] o_block_select_lines_n,
  output bwu_cyc_type o_cyc_type,
  output logic o_busy,
  output logic o_done,
  output logic o_page_hit
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    bwu_st_type st;
    logic [1:0] rdy_sync;
    logic [2:0] cnt;
    logic rdy_eff;
    bwu_cyc_type cyc;
    logic [3:0] cs_n;
    logic done;
    logic hit;
    logic page_valid;
    logic [BWU_ADDR_W-1:BWU_PAGE_LSB] last_page;
  } bwu_state_type;

  bwu_state_type state_r;
  bwu_state_type state_nxt;

  // page compare with masked low page bits
  function automatic logic page_eq(
    input logic [BWU_ADDR_W-1:BWU_PAGE_LSB] a,
    input logic [BWU_ADDR_W-1:BWU_PAGE_LSB] b,
    input logic [BWU_PAGE_W-1:0] mask
  );
    logic [BWU_ADDR_W-1:BWU_PAGE_LSB] m;
    m = '1;
    m[BWU_PAGE_LSB+BWU_PAGE_W-1:BWU_PAGE_LSB] = ~mask;
    return ((a ^ b) & m) == '0;
  endfunction

  // ---------------------------------------------------------------
  // decode of the incoming request
  // ---------------------------------------------------------------
  logic [1:0] blk;
  logic hit_now;
  bwu_cyc_type cyc_d;
  logic [2:0] waits_d;
  logic rdy_d;

  // blocks are the top address bits, each 16 MB wide
  // sixteen megabyte blocks
  assign blk = i_req.addr[BWU_ADDR_W-1:BWU_BLK_LSB];
  assign hit_now = state_r.page_valid &&
                   page_eq(i_req.addr[BWU_ADDR_W-1:BWU_PAGE_LSB],
                           state_r.last_page, i_cfg.page_mask);

  // cycle type selection and wait count per type
  always_comb
  begin
    cyc_d = BWU_CYC_SRAM;
    waits_d = i_cfg.waits[blk];
    rdy_d = 1'b1;
    if (i_req.refresh)
    begin
      cyc_d = BWU_CYC_REFRESH;
      waits_d = BWU_REFRESH_WAITS;
    end
    else if (i_req.halt_ack)
    begin
      cyc_d = BWU_CYC_HALT;
      waits_d = BWU_HALT_WAITS;
      rdy_d = 1'b0;
    end
    else if (i_req.fault && i_req.io && i_req.write &&
             blk == BWU_BLK_FAULT)
    begin
      cyc_d = BWU_CYC_FAULT;
    end
    else if (i_req.io)
    begin
      if (blk == BWU_BLK_INTIO)
      begin
        cyc_d = BWU_CYC_INTIO;
        waits_d = BWU_INTIO_BASE + {2'h0, i_cfg.intio_extra};
        rdy_d = 1'b0;
      end
      else
        cyc_d = BWU_CYC_EXTIO;
    end
    else if (blk == BWU_BLK_DRAM && i_cfg.dram_en)
    begin
      cyc_d = BWU_CYC_DRAM;
      if (i_req.flyby)
      begin
        // dma off-page never below its floor, on-page ignores ready
        rdy_d = !hit_now;
        if (!hit_now && i_cfg.waits[blk] < BWU_DMA_DRAM_OFF_MIN)
          waits_d = BWU_DMA_DRAM_OFF_MIN;
      end
      else if (hit_now)
      begin
        waits_d = {2'h0, i_cfg.dram_extra};
        rdy_d = 1'b0;
      end
      else
        waits_d = BWU_DRAM_OFF_BASE + {2'h0, i_cfg.dram_extra};
    end
    else if (blk == BWU_BLK_PROM && i_cfg.prom_en)
    begin
      cyc_d = BWU_CYC_PROM;
      rdy_d = 1'b0;
      if (hit_now && !i_req.flyby)
        waits_d = i_cfg.prom_page_waits;
    end
  end

  // ---------------------------------------------------------------
  // cycle sequencer
  // ---------------------------------------------------------------
  logic rdy_act;
  // second sync stage only; ready pin is active low
  assign rdy_act = !state_r.rdy_sync[1];

  always_comb
  begin
    state_nxt = state_r;
    state_nxt.done = 1'b0;
    state_nxt.rdy_sync = {state_r.rdy_sync[0], i_ready_n};
    case (state_r.st)
      BWU_ST_IDLE:
      begin
        if (i_req.start)
        begin
          state_nxt.cyc = cyc_d;
          state_nxt.cnt = waits_d;
          state_nxt.rdy_eff = rdy_d;
          state_nxt.hit = hit_now;
          state_nxt.cs_n = '1;
          if (!i_req.refresh && !i_req.halt_ack)
            state_nxt.cs_n[blk] = 1'b0;
          if (cyc_d == BWU_CYC_DRAM || cyc_d == BWU_CYC_PROM)
          begin
            state_nxt.page_valid = 1'b1;
            state_nxt.last_page = i_req.addr[BWU_ADDR_W-1:BWU_PAGE_LSB];
          end
          else
            state_nxt.page_valid = 1'b0;
          state_nxt.st = (waits_d == 3'h0) ? BWU_ST_READY : BWU_ST_WAIT;
        end
      end
      BWU_ST_WAIT:
      begin
        state_nxt.cnt = state_r.cnt - 3'h1;
        if (state_r.cnt == 3'h1)
          state_nxt.st = BWU_ST_READY;
      end
      BWU_ST_READY:
      begin
        if (!state_r.rdy_eff || rdy_act)
        begin
          state_nxt.done = 1'b1;
          state_nxt.cs_n = '1;
          state_nxt.st = BWU_ST_IDLE;
        end
      end
      default:
        state_nxt.st = BWU_ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_r <= '{st: BWU_ST_IDLE, rdy_sync: 2'h3, cnt: 3'h0,
                   rdy_eff: 1'b0, cyc: BWU_CYC_NONE, cs_n: 4'hF,
                   done: 1'b0, hit: 1'b0, page_valid: 1'b0,
                   last_page: '0};
    end
    else
      state_r <= state_nxt;
  end

  // outputs from flops; busy is a handshake level
  assign o_block_select_lines_n = state_r.cs_n;
  assign o_cyc_type = state_r.cyc;
  assign o_busy = state_r.st != BWU_ST_IDLE;
  assign o_done = state_r.done;
  assign o_page_hit = state_r.hit;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_one_select;
    @(posedge i_clk) disable iff (i_rst)
      $countones(~state_r.cs_n) <= 1;
  endproperty
  a_one_select: assert property (p_one_select)
    else $error("more than one block select active");

  property p_dram_blk0;
    @(posedge i_clk) disable iff (i_rst)
      state_r.cyc == BWU_CYC_DRAM && o_busy |-> !state_r.cs_n[0];
  endproperty
  a_dram_blk0: assert property (p_dram_blk0)
    else $error("dram cycle outside block 0");

  property p_prom_blk3;
    @(posedge i_clk) disable iff (i_rst)
      state_r.cyc == BWU_CYC_PROM && o_busy |-> !state_r.cs_n[3];
  endproperty
  a_prom_blk3: assert property (p_prom_blk3)
    else $error("page-rom cycle outside block 3");

  property p_zero_wait;
    @(posedge i_clk) disable iff (i_rst)
      state_r.st == BWU_ST_IDLE && i_req.start && waits_d == 3'h0 &&
      !rdy_d |=> ##1 o_done;
  endproperty
  a_zero_wait: assert property (p_zero_wait)
    else $error("zero-wait cycle not done after two edges");

  property p_wait_len;
    @(posedge i_clk) disable iff (i_rst)
      state_r.st == BWU_ST_IDLE && i_req.start && waits_d == 3'h3 &&
      !rdy_d |=> !o_done [*3] ##1 (state_r.st == BWU_ST_READY) ##1 o_done;
  endproperty
  a_wait_len: assert property (p_wait_len)
    else $error("three programmed waits not honoured");

  property p_ready_holds;
    @(posedge i_clk) disable iff (i_rst)
      state_r.st == BWU_ST_READY && state_r.rdy_eff && !rdy_act |=>
      !o_done && o_busy;
  endproperty
  a_ready_holds: assert property (p_ready_holds)
    else $error("cycle ended with ready inactive");

  property p_ready_ignored;
    @(posedge i_clk) disable iff (i_rst)
      state_r.st == BWU_ST_READY && !state_r.rdy_eff |=> o_done;
  endproperty
  a_ready_ignored: assert property (p_ready_ignored)
    else $error("ready waited on where it is ignored");

  property p_intio_waits;
    @(posedge i_clk) disable iff (i_rst)
      state_r.st == BWU_ST_IDLE && i_req.start &&
      cyc_d == BWU_CYC_INTIO |-> waits_d inside {3'h1, 3'h2} && !rdy_d;
  endproperty
  a_intio_waits: assert property (p_intio_waits)
    else $error("internal io waits out of range");

  property p_dram_on;
    @(posedge i_clk) disable iff (i_rst)
      i_req.start && cyc_d == BWU_CYC_DRAM && hit_now && !i_req.flyby
      |-> waits_d <= 3'h1 && !rdy_d;
  endproperty
  a_dram_on: assert property (p_dram_on)
    else $error("dram on-page timing wrong");

  property p_fault_waits;
    @(posedge i_clk) disable iff (i_rst)
      state_r.st == BWU_ST_IDLE && i_req.start && cyc_d == BWU_CYC_FAULT
      |-> waits_d == i_cfg.waits[BWU_BLK_FAULT] && rdy_d;
  endproperty
  a_fault_waits: assert property (p_fault_waits)
    else $error("machine fault cycle timing wrong");

  property p_flyby_prom;
    @(posedge i_clk) disable iff (i_rst)
      state_r.st == BWU_ST_IDLE && i_req.start && cyc_d == BWU_CYC_PROM &&
      i_req.flyby |-> waits_d == i_cfg.waits[BWU_BLK_PROM] && !rdy_d;
  endproperty
  a_flyby_prom: assert property (p_flyby_prom)
    else $error("fly-by page-rom timing wrong");

  c_dram: cover property (@(posedge i_clk) disable iff (i_rst)
    o_done && state_r.cyc == BWU_CYC_DRAM && state_r.hit);
  c_prom: cover property (@(posedge i_clk) disable iff (i_rst)
    o_done && state_r.cyc == BWU_CYC_PROM);
  c_stretch: cover property (@(posedge i_clk) disable iff (i_rst)
    state_r.st == BWU_ST_READY && state_r.rdy_eff && !rdy_act);

endmodule

// ===== core/bwu_pkg.sv
// package for the bus wait unit: constants, types and behaviour notes
//
// Notes on behaviour
// - decode four blocks, one select each, choose cycle type per access
// - blocks exist in both memory space and I/O space
// - each block spans a contiguous 16 megabyte range
// - programmable zero to seven automatic waits, separately per block
// - inactive ready stretches eligible cycles until ready seen active
// - page-ROM cycles only selectable on block 3
// - DRAM cycles only selectable on block 0
// - static memory cycles: 0-7 programmed waits plus ready
// - DRAM off-page 2 or 3 waits with ready; on-page 0 or 1, no ready; fly-by DMA uses block 0 waits, off-page at least 2
// - external I/O on blocks 0-2: 0-7 waits plus ready
// - internal I/O in block 3: 1 or 2 waits, ready ignored
// - machine fault, I/O block 0 write: 0-7 waits, ready honoured
// - fly-by DMA page-ROM: 0-7 waits both pages, ready ignored
// - page-ROM on-page decided against address latched last cycle
package bwu_pkg;

  // ---------------------------------------------------------------
  // address layout
  // ---------------------------------------------------------------
  localparam int BWU_ADDR_W = 26;
  localparam int BWU_BLK_LSB = 24;
  localparam int BWU_PAGE_LSB = 3;
  localparam int BWU_PAGE_W = 3;
  localparam logic [1:0] BWU_BLK_DRAM = 2'h0;
  localparam logic [1:0] BWU_BLK_PROM = 2'h3;
  localparam logic [1:0] BWU_BLK_FAULT = 2'h0;
  localparam logic [1:0] BWU_BLK_INTIO = 2'h3;

  // ---------------------------------------------------------------
  // fixed wait figures
  // ---------------------------------------------------------------
  localparam logic [2:0] BWU_DRAM_OFF_BASE = 3'h2;
  localparam logic [2:0] BWU_DMA_DRAM_OFF_MIN = 3'h2;
  localparam logic [2:0] BWU_INTIO_BASE = 3'h1;
  localparam logic [2:0] BWU_REFRESH_WAITS = 3'h3;
  localparam logic [2:0] BWU_HALT_WAITS = 3'h0;
  localparam logic [2:0] BWU_WAIT_RST = 3'h7;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    BWU_CYC_SRAM = 4'h0,
    BWU_CYC_DRAM = 4'h1,
    BWU_CYC_PROM = 4'h2,
    BWU_CYC_EXTIO = 4'h3,
    BWU_CYC_INTIO = 4'h4,
    BWU_CYC_REFRESH = 4'h5,
    BWU_CYC_HALT = 4'h6,
    BWU_CYC_FAULT = 4'h7,
    BWU_CYC_NONE = 4'hF
  } bwu_cyc_type;

  typedef enum logic [1:0] {
    BWU_ST_IDLE = 2'h0,
    BWU_ST_WAIT = 2'h1,
    BWU_ST_READY = 2'h3
  } bwu_st_type;

  // request from the core
  typedef struct packed {
    logic start;
    logic [BWU_ADDR_W-1:0] addr;
    logic io;
    logic write;
    logic refresh;
    logic halt_ack;
    logic fault;
    logic flyby;
  } bwu_req_type;

  // configuration: per-block waits and shared settings
  typedef struct packed {
    logic [3:0][2:0] waits;
    logic dram_en;
    logic prom_en;
    logic [2:0] prom_page_waits;
    logic dram_extra;
    logic intio_extra;
    logic [BWU_PAGE_W-1:0] page_mask;
  } bwu_cfg_type;

endpackage

// ===== sim/bwu_bus_wait_unit_test.sv
// self-checking bench for the bus wait unit
`timescale 1ns/1ps
module bwu_bus_wait_unit_test;
  import bwu_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  bwu_req_type req = '0;
  bwu_cfg_type cfg = '0;
  logic [3:0] dly = 4'h0;
  logic rdy_n;
  logic [3:0] sel_n;
  bwu_cyc_type cyc_t;
  logic busy;
  logic done;
  logic hit;
  int fails = 0;
  int n_checks = 0;
  int ticks = 0;
  int wt [4] = '{3, 5, 0, 7};
  logic [17:0] ofs = 18'h3FFFF;

  bwu_bus_wait_unit i_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_req(req), .i_cfg(cfg),
    .i_ready_n(rdy_n), .o_block_select_lines_n(sel_n),
    .o_cyc_type(cyc_t), .o_busy(busy), .o_done(done), .o_page_hit(hit));
  bwu_ready_model i_far (
    .i_clk(i_clk), .i_busy(busy), .i_delay(dly), .o_ready_n(rdy_n));

  // ------------------------------------------------------------
  // clock and hang guard
  // ------------------------------------------------------------
  always #50 i_clk = ~i_clk;
  // whole run needs well under a thousand cycles
  always @(posedge i_clk)
  begin
    ticks = ticks + 1;
    if (ticks == 5000)
    begin
      fails = fails + 1;
      end_of_test();
    end
  end

  // ------------------------------------------------------------
  // checking and access tasks
  // ------------------------------------------------------------
  task end_of_test;
    if (fails == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("BAD %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  // one access at offset ofs in the block; f = io,wr,refresh,halt,fault,flyby
  // done is expected ew+1 edges after the taking edge unless ready slows it
  task run(input logic [1:0] b, input logic [5:0] f, input logic [2:0] pg,
    input bwu_cyc_type et, input int ew, input logic [3:0] es,
    input logic eh, input logic h);
    int n;
    @(posedge i_clk);
    req <= {1'b1, b, ofs, pg, ofs[2:0], f};
    @(posedge i_clk);
    req.start <= 1'b0;
    #1;
    if (es !== 4'hX)
      chk(sel_n, es);
    chk(busy, 1'b1);
    n = 0;
    while (done !== 1'b1 && n < 60)
    begin
      @(posedge i_clk);
      #1;
      n = n + 1;
    end
    chk(cyc_t, et);
    chk(busy, 1'b0);
    chk(hit, eh);
    if (h && dly != 4'h0)
      chk(n > ew + 1 && n < 60, 1);
    else
      chk(n, ew + 1);
    chk(sel_n, 4'hF);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    cfg.waits = {3'h7, 3'h0, 3'h5, 3'h3};
    repeat (9) @(posedge i_clk);
    #1;
    chk({sel_n, cyc_t, busy, done, hit}, {8'hFF, 3'h0});
    @(posedge i_clk);
    i_rst <= 1'b0;
    // static cycles at offset FFFFC7 of each block, page bits zero
    for (int b = 0; b < 4; b++)
      run(b[1:0], 6'h00, 3'h0, BWU_CYC_SRAM, wt[b], ~(4'h1 << b), 0, 1);
    @(posedge i_clk) dly <= 4'hC;
    for (int b = 0; b < 4; b++)
      run(b[1:0], 6'h00, 3'h0, BWU_CYC_SRAM, wt[b], ~(4'h1 << b), 0, 1);
    for (int b = 0; b < 3; b++)
      run(b[1:0], 6'h20, 3'h0, BWU_CYC_EXTIO, wt[b], ~(4'h1 << b), 0, 1);
    run(3, 6'h20, 3'h0, BWU_CYC_INTIO, 1, 4'h7, 0, 0);
    @(posedge i_clk) cfg.intio_extra <= 1'b1;
    run(3, 6'h20, 3'h0, BWU_CYC_INTIO, 2, 4'h7, 0, 0);
    run(0, 6'h32, 3'h0, BWU_CYC_FAULT, 3, 4'hE, 0, 1);
    run(1, 6'h08, 3'h0, BWU_CYC_REFRESH, 3, 4'hF, 0, 1);
    run(2, 6'h04, 3'h0, BWU_CYC_HALT, 0, 4'hF, 0, 0);
    // dram with ready strapped so off-page figures are exact
    @(posedge i_clk) dly <= 4'h0;
    @(posedge i_clk) cfg.dram_en <= 1'b1;
    run(0, 6'h00, 3'h1, BWU_CYC_DRAM, 2, 4'hE, 0, 1);
    run(0, 6'h00, 3'h1, BWU_CYC_DRAM, 0, 4'hE, 1, 0);
    @(posedge i_clk) cfg.dram_extra <= 1'b1;
    run(0, 6'h00, 3'h1, BWU_CYC_DRAM, 1, 4'hE, 1, 0);
    run(0, 6'h00, 3'h2, BWU_CYC_DRAM, 3, 4'hE, 0, 1);
    run(0, 6'h01, 3'h2, BWU_CYC_DRAM, 3, 4'hE, 1, 0);
    run(1, 6'h00, 3'h2, BWU_CYC_SRAM, 5, 4'hD, 0, 1);
    // page-rom against a slow ready that must not matter
    @(posedge i_clk) dly <= 4'hC;
    @(posedge i_clk) cfg.prom_en <= 1'b1;
    @(posedge i_clk) cfg.prom_page_waits <= 3'h2;
    run(3, 6'h00, 3'h4, BWU_CYC_PROM, 7, 4'h7, 0, 0);
    run(3, 6'h00, 3'h4, BWU_CYC_PROM, 2, 4'h7, 1, 0);
    @(posedge i_clk) cfg.page_mask <= 3'h1;
    run(3, 6'h00, 3'h5, BWU_CYC_PROM, 2, 4'h7, 1, 0);
    run(3, 6'h01, 3'h5, BWU_CYC_PROM, 7, 4'h7, 1, 0);
    run(3, 6'h01, 3'h0, BWU_CYC_PROM, 7, 4'h7, 0, 0);
    run(2, 6'h00, 3'h0, BWU_CYC_SRAM, 0, 4'hB, 0, 1);
    // low end of block 1 in both spaces
    @(posedge i_clk) ofs <= 18'h0;
    run(1, 6'h00, 3'h0, BWU_CYC_SRAM, 5, 4'hD, 0, 1);
    run(1, 6'h20, 3'h0, BWU_CYC_EXTIO, 5, 4'hD, 0, 1);
    end_of_test();
  end
endmodule

// ===== sim/bwu_ready_model.sv
// far side model: memories and I/O devices answering on the ready pin
`timescale 1ns/1ps
module bwu_ready_model
(
  // clock and cycle in progress
  input wire logic i_clk,
  input wire logic i_busy,
  // not-ready cycles per access, zero means ready strapped active
  input wire logic [3:0] i_delay,
  // ready pin, low = ready
  output logic o_ready_n
);
  logic [3:0] cnt_r;

  // ------------------------------------------------------------
  // response timing
  // ------------------------------------------------------------
  // count cycles of the access, saturating so it never wraps
  always_ff @(posedge i_clk)
  begin
    if (!i_busy)
      cnt_r <= 4'h0;
    else if (cnt_r != 4'hF)
      cnt_r <= cnt_r + 4'h1;
  end
  // hold ready off
  // pulled up between cycles unless i_delay is zero, when the idle line reads as ready
  assign o_ready_n = (i_delay != 4'h0) && (!i_busy || (cnt_r < i_delay));
endmodule
